/* rtl/csmsf_top.sv */
// Purpose: status, overflow math and scan-time watchdog logic
// Assumes: classic wishbone slave, single clock, synchronous reset
// Notes:   math unit computes 16-bit signed ops in one cycle
// Contract
// - reply flag set on data, cleared when stored
// - outgoing flag: waiting and none transmitting
// - overflow sets arithmetic and trap flags always
// - wrap mode writes low sixteen result bits
// - saturate mode clamps to full scale
// - overflow selection defaults to saturate
// - selection ignored for double divide, math register
// - scan byte zeroed before first main rung
// - scan byte counts one per 10 ms tick
// - scan byte equal limit gives watchdog fault
// - count resolution is plus zero minus one tick
// - timed cycle covers whole program cycle
// - limit byte defaults ten, range one to max
// - trap set at program end gives fault
`timescale 1ns/10ps
`default_nettype none
module csmsf_top #(
    parameter int TICK_PERIOD = csmsf_pkg::TICK_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // wishbone classic slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic [31:0]      dat_o,
    output logic             ack_o,
    // network side events, same clock domain
    input  wire logic        reply_rx_i,     // remote delivered reply data
    input  wire logic        reply_done_i,   // reply stored, msg updated
    input  wire logic        msg_waiting_i,  // enabled messages waiting
    input  wire logic        msg_xmit_i,     // a message transmitting
    // executor side events
    input  wire logic        scan_start_i,   // just before first main rung
    input  wire logic        prog_end_i,     // end or temporary_end executed
    // outputs
    output logic             fault_o,        // major fault declared
    output logic [15:0]      fault_code_o,
    output logic             irq_o
);
    // local names for shared constants; spelled out from the package
    // rather than imported, so a clash with a local name cannot hide
    localparam int          EV_W           = csmsf_pkg::EV_W;
    localparam int          EV_OVF         = csmsf_pkg::EV_OVF;
    localparam int          EV_FAULT       = csmsf_pkg::EV_FAULT;
    localparam int          EV_REPLY       = csmsf_pkg::EV_REPLY;
    localparam int          EV_OUT         = csmsf_pkg::EV_OUT;
    localparam int          BIT_REPLY_PEND = csmsf_pkg::BIT_REPLY_PEND;
    localparam int          BIT_OUT_PEND   = csmsf_pkg::BIT_OUT_PEND;
    localparam int          BIT_OVF_SEL    = csmsf_pkg::BIT_OVF_SEL;
    localparam int          BIT_ARITH_OVF  = csmsf_pkg::BIT_ARITH_OVF;
    localparam int          BIT_OVF_TRAP   = csmsf_pkg::BIT_OVF_TRAP;
    localparam int          BIT_FAULT_CLR  = csmsf_pkg::BIT_FAULT_CLR;
    localparam int          BIT_CTL_START  = csmsf_pkg::BIT_CTL_START;
    localparam int          BIT_CTL_END    = csmsf_pkg::BIT_CTL_END;
    localparam logic        OVF_SEL_RST    = csmsf_pkg::OVF_SEL_RST;
    localparam logic [7:0]  WDOG_RESET     = csmsf_pkg::WDOG_RESET;
    localparam logic [15:0] FAULT_WDOG     = csmsf_pkg::FAULT_WDOG;
    localparam logic [15:0] FAULT_MINOR    = csmsf_pkg::FAULT_MINOR;
    localparam logic [1:0]  OP_ADD         = csmsf_pkg::OP_ADD;
    localparam logic [1:0]  OP_SUB         = csmsf_pkg::OP_SUB;
    localparam logic [1:0]  OP_MUL         = csmsf_pkg::OP_MUL;
    localparam logic [1:0]  OP_DIV         = csmsf_pkg::OP_DIV;

    if (TICK_PERIOD < 2) begin : g_chk
        $error("csmsf_top: TICK_PERIOD must be at least 2");
    end

    // registers
    logic        reply_q;        // reply pending flag
    logic        out_q;          // outgoing message pending flag
    logic        ovf_sel_q;      // overflow selection bit
    logic [7:0]  scan_q;         // scan time byte
    logic [7:0]  wdog_q;         // watchdog limit byte
    logic        arith_ovf_q;    // arithmetic overflow flag
    logic        trap_q;         // overflow trap flag
    logic [15:0] opa_q;          // operand a
    logic [15:0] opb_q;          // operand b
    logic [15:0] dest_q;         // destination word
    logic [15:0] mreg_q;         // math register, high word / remainder
    logic [EV_W-1:0] ist_q;      // sticky interrupt status
    logic [EV_W-1:0] imask_q;    // interrupt mask
    logic        scan_run_q;     // a scan is being timed
    logic        ack_q;

    // bus decode
    wire bus_req = cyc_i & stb_i & ~ack_q;
    wire wr      = bus_req & we_i;
    wire rd      = bus_req & ~we_i;
    wire sel_s2  = (adr_i == csmsf_pkg::ADR_STATUS2);
    wire sel_sc  = (adr_i == csmsf_pkg::ADR_SCAN);
    wire sel_fl  = (adr_i == csmsf_pkg::ADR_FLAGS);
    wire sel_op  = (adr_i == csmsf_pkg::ADR_MATH_OP);
    wire sel_cmd = (adr_i == csmsf_pkg::ADR_MATH_CMD);
    wire sel_ist = (adr_i == csmsf_pkg::ADR_IRQ_STAT);
    wire sel_imk = (adr_i == csmsf_pkg::ADR_IRQ_MASK);
    wire sel_ctl = (adr_i == csmsf_pkg::ADR_CTRL);
    wire wr_s2   = wr & sel_s2 & sel_i[1];
    wire wr_wd   = wr & sel_sc & sel_i[1];
    wire wr_fl   = wr & sel_fl & sel_i[0];
    wire wr_op   = wr & sel_op;
    wire go_math = wr & sel_cmd & sel_i[0];
    wire rd_ist  = rd & sel_ist;
    wire wr_imk  = wr & sel_imk & sel_i[0];
    // software scan strobes: bit0 start, bit1 end
    wire sw_start = wr & sel_ctl & sel_i[0] & dat_i[BIT_CTL_START];
    wire sw_end   = wr & sel_ctl & sel_i[0] & dat_i[BIT_CTL_END];
    wire start    = scan_start_i | sw_start;
    wire pend     = prog_end_i | sw_end;

    // 10 ms tick, restarted with the scan so count is +0/-1 tick
    logic tick;
    csmsf_tick #(.PERIOD(TICK_PERIOD)) u_tick (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .ce_i   (ce_i),
        .clr_i  (start),
        .tick_o (tick)
    );

    // math unit: 32-bit true result then overflow handling
    wire [1:0]         op      = dat_i[1:0];
    wire signed [15:0] sa      = opa_q;
    wire signed [15:0] sb      = opb_q;
    wire signed [31:0] r_add   = 32'(sa) + 32'(sb);
    wire signed [31:0] r_sub   = 32'(sa) - 32'(sb);
    wire signed [31:0] r_mul   = 32'(sa) * 32'(sb);
    wire               div0    = (opb_q == 16'h0000);
    wire signed [31:0] r_div   = div0 ? 32'sh0000_0000 : 32'(sa) / 32'(sb);
    wire signed [15:0] r_rem   = div0 ? 16'sh0000 : sa % sb;
    wire signed [31:0] res     = (op == OP_ADD) ? r_add :
                                 (op == OP_SUB) ? r_sub :
                                 (op == OP_MUL) ? r_mul : r_div;
    // overflow when result leaves signed 16-bit range; divide by zero too
    wire fits   = (res >= 32'shFFFF_8000) && (res <= 32'sh0000_7FFF);
    wire ovf    = ~fits | ((op == OP_DIV) & div0);
    wire [15:0] sat = res[31] ? 16'h8000 : 16'h7FFF;
    wire [15:0] dst = ~ovf ? res[15:0] :
                      ovf_sel_q ? res[15:0] : sat;
    // math register ignores selection bit
    wire [15:0] mreg = (op == OP_DIV) ? 16'(r_rem) : res[31:16];

    // watchdog and end-of-program checks
    wire wd_hit  = scan_run_q & (scan_q == wdog_q);
    wire end_hit = pend & (trap_q | (go_math & ovf));
    wire [EV_W-1:0] ev;
    assign ev[EV_OVF]   = go_math & ovf;
    assign ev[EV_FAULT] = (wd_hit | end_hit) & ~fault_o;
    assign ev[EV_REPLY] = reply_rx_i;
    assign ev[EV_OUT]   = msg_waiting_i & ~msg_xmit_i & ~out_q;
    // write data of limit byte: zero is out of range, keep one
    wire [7:0] wd_new = (dat_i[15:8] == 8'h00) ? 8'h01 : dat_i[15:8];

    // read mux
    logic [31:0] rdata;
    always_comb begin
        rdata = 32'h0000_0000;
        if (sel_s2) begin
            rdata[BIT_REPLY_PEND] = reply_q;
            rdata[BIT_OUT_PEND]   = out_q;
            rdata[BIT_OVF_SEL]    = ovf_sel_q;
        end
        if (sel_sc) rdata[15:0] = {wdog_q, scan_q};
        if (sel_fl) begin
            rdata[BIT_OVF_TRAP]  = trap_q;
            rdata[BIT_ARITH_OVF] = arith_ovf_q;
            rdata[31:16]         = fault_code_o;
        end
        if (sel_op)  rdata = {opb_q, opa_q};
        if (sel_cmd) rdata = {mreg_q, dest_q};
        if (sel_ist) rdata[EV_W-1:0] = ist_q;
        if (sel_imk) rdata[EV_W-1:0] = imask_q;
    end

    // bus answer: registered ack one cycle after the request, ack drops next cycle
    // ack_q blocks a second take while the master still holds the strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_q <= bus_req;
            ack_o <= bus_req;
            dat_o <= rd ? rdata : 32'h0000_0000;
        end
    end

    // message flags
    // outgoing flag is a plain registered level: it drops as soon as a
    // transmission starts and returns while more messages wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reply_q <= 1'b0;
            out_q   <= 1'b0;
        end else if (ce_i) begin
            // set wins over clear
            if (reply_rx_i)        reply_q <= 1'b1;
            else if (reply_done_i) reply_q <= 1'b0;
            out_q <= msg_waiting_i & ~msg_xmit_i;
        end
    end

    // overflow selection, writable by software
    // only software moves it; the program is expected to refresh it
    always_ff @(posedge clk_i) begin
        if (rst_i)
            ovf_sel_q <= OVF_SEL_RST;
        else if (ce_i && wr_s2)
            ovf_sel_q <= dat_i[BIT_OVF_SEL];
    end

    // math execution and overflow flags
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            opa_q       <= 16'h0000;
            opb_q       <= 16'h0000;
            dest_q      <= 16'h0000;
            mreg_q      <= 16'h0000;
            arith_ovf_q <= 1'b0;
            trap_q      <= 1'b0;
        end else if (ce_i) begin
            if (wr_op) begin
                opa_q <= dat_i[15:0];
                opb_q <= dat_i[31:16];
            end
            if (go_math) begin
                dest_q <= dst;
                if (op == OP_MUL || op == OP_DIV) mreg_q <= mreg;
            end
            // set wins over software clear
            if (go_math && ovf) begin
                arith_ovf_q <= 1'b1;
                trap_q      <= 1'b1;
            end else if (wr_fl) begin
                arith_ovf_q <= dat_i[BIT_ARITH_OVF];
                trap_q      <= dat_i[BIT_OVF_TRAP];
            end
        end
    end

    // scan timer: covers the whole cycle from start to next start
    // the first increment follows the start at once, so a count of n
    // means n-1 to n ticks have passed; counting halts while faulted
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_q     <= 8'h00;
            scan_run_q <= 1'b0;
            wdog_q     <= WDOG_RESET;
        end else if (ce_i) begin
            if (wr_wd) wdog_q <= wd_new;
            if (start) begin
                scan_q     <= 8'h00;
                scan_run_q <= 1'b1;
            end else if (tick && scan_run_q && !fault_o) begin
                scan_q <= scan_q + 8'h01;
            end
        end
    end

    // major fault latch, cleared by writing bit 2 of flags register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault_o      <= 1'b0;
            fault_code_o <= 16'h0000;
        end else if (ce_i) begin
            if (!fault_o && wd_hit) begin
                fault_o      <= 1'b1;
                fault_code_o <= FAULT_WDOG;
            end else if (!fault_o && end_hit) begin
                fault_o      <= 1'b1;
                fault_code_o <= FAULT_MINOR;
            // a clear only lands on a latched fault, never blocks a new one
            end else if (wr_fl && dat_i[BIT_FAULT_CLR]) begin
                fault_o      <= 1'b0;
                fault_code_o <= 16'h0000;
            end
        end
    end

    // interrupt status: sticky, cleared by read, set wins
    // irq uses the same next status value, so it rises with the bit
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ist_q   <= '0;
            imask_q <= '0;
            irq_o   <= 1'b0;
        end else if (ce_i) begin
            ist_q <= (rd_ist ? '0 : ist_q) | ev;
            if (wr_imk) imask_q <= dat_i[EV_W-1:0];
            irq_o <= |(((rd_ist ? '0 : ist_q) | ev) & imask_q);
        end
    end
endmodule : csmsf_top
`default_nettype wire

/* rtl/csmsf_pkg.sv */
// Purpose: shared constants for the controller status math/scan flags block
// Assumes: 25 MHz clock, classic wishbone register access
// Notes:   offsets are byte addresses of 32-bit words
package csmsf_pkg;
    // register byte offsets
    localparam logic [7:0] ADR_STATUS2   = 8'h00; // status word two
    localparam logic [7:0] ADR_SCAN      = 8'h04; // scan time / watchdog
    localparam logic [7:0] ADR_FLAGS     = 8'h08; // overflow flags, fault
    localparam logic [7:0] ADR_MATH_OP   = 8'h0C; // operand a / b
    localparam logic [7:0] ADR_MATH_CMD  = 8'h10; // op select / result
    localparam logic [7:0] ADR_IRQ_STAT  = 8'h14; // sticky events
    localparam logic [7:0] ADR_IRQ_MASK  = 8'h18; // interrupt mask
    localparam logic [7:0] ADR_CTRL      = 8'h1C; // scan control strobes
    // status word two field positions
    localparam int BIT_REPLY_PEND  = 6;
    localparam int BIT_OUT_PEND    = 7;
    localparam int BIT_OVF_SEL     = 14;
    // flag register field positions
    localparam int BIT_ARITH_OVF   = 1;
    localparam int BIT_OVF_TRAP    = 0;
    localparam int BIT_FAULT_CLR   = 2;  // write one to drop the fault
    // control register strobe positions
    localparam int BIT_CTL_START   = 0;
    localparam int BIT_CTL_END     = 1;
    // reset values
    localparam logic [7:0]  WDOG_RESET   = 8'h0A; // ten ticks
    localparam logic        OVF_SEL_RST  = 1'b0;  // saturating by default
    // fault codes
    localparam logic [15:0] FAULT_WDOG   = 16'h0022;
    localparam logic [15:0] FAULT_MINOR  = 16'h0020;
    // math op codes
    localparam logic [1:0]  OP_ADD = 2'h0;
    localparam logic [1:0]  OP_SUB = 2'h1;
    localparam logic [1:0]  OP_MUL = 2'h2;
    localparam logic [1:0]  OP_DIV = 2'h3;
    // tick timing
    localparam int CLK_HZ      = 25_000_000;
    localparam int TICK_MS     = 10;
    localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    // event bit positions in irq status
    localparam int EV_OVF   = 0;
    localparam int EV_FAULT = 1;
    localparam int EV_REPLY = 2;
    localparam int EV_OUT   = 3;
    localparam int EV_W     = 4;
endpackage : csmsf_pkg

/* rtl/csmsf_tick.sv */
// Purpose: fixed divider yielding one single-cycle tick pulse per period
// Assumes: clock enable freezes the count
// Notes:   tick output is registered; a restart fires a tick at once
`timescale 1ns/10ps
`default_nettype none
module csmsf_tick #(
    parameter int PERIOD = csmsf_pkg::TICK_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    input  wire logic clr_i,   // restart period, e.g. at scan start
    output logic      tick_o
);
    localparam int CW = $clog2(PERIOD);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    // a period below two cannot form a pulse between idle cycles
    if (PERIOD < 2) begin : g_chk
        $error("csmsf_tick: PERIOD must be at least 2");
    end

    logic [CW-1:0] cnt_q;   // cycles into current period
    wire           wrap = (cnt_q == LAST);

    // divider count and pulse, restart aligns ticks to scan start
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_q  <= '0;
            tick_o <= 1'b0;
        end else if (ce_i) begin
            if (clr_i) begin
                // tick at once, so a count of n means n-1 to n periods
                cnt_q  <= '0;
                tick_o <= 1'b1;
            end else begin
                cnt_q  <= wrap ? '0 : cnt_q + 1'b1;
                tick_o <= wrap;
            end
        end
    end
endmodule : csmsf_tick
`default_nettype wire

/* tb/csmsf_top_sva.sv */
// Purpose: port checks for the status math scan block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound onto every csmsf_top
`timescale 1ns/10ps
`default_nettype none
module csmsf_top_sva #(
    parameter int TICK_PERIOD = 8
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        fault_o,
    input wire logic [15:0] fault_code_o,
    input wire logic        irq_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // software fault clear request
    wire clr_w = cyc_i && stb_i && we_i && dat_i[2]
                 && adr_i == csmsf_pkg::ADR_FLAGS;
    // only these accesses may lower the interrupt
    wire irq_acc = cyc_i && stb_i && (adr_i == csmsf_pkg::ADR_IRQ_STAT
                   || adr_i == csmsf_pkg::ADR_IRQ_MASK);
    a_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack held too long");
    a_ack_answers: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
        else $error("request not acked");
    a_ack_cause: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("ack without request");
    a_data_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    a_reset_quiet: assert property ($past(rst_i) |-> !ack_o && !fault_o && !irq_o)
        else $error("outputs active after reset");
    a_fault_code: assert property (fault_o |-> fault_code_o == csmsf_pkg::FAULT_WDOG || fault_code_o == csmsf_pkg::FAULT_MINOR)
        else $error("bad fault code");
    a_fault_held: assert property (fault_o && !clr_w |=> fault_o)
        else $error("fault dropped by itself");
    a_irq_drop: assert property ($fell(irq_o) |-> $past(irq_acc) || $past(rst_i))
        else $error("irq dropped without access");
endmodule : csmsf_top_sva
bind csmsf_top csmsf_top_sva #(.TICK_PERIOD(TICK_PERIOD)) u_csmsf_top_sva (
    .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_i, .dat_o,
    .ack_o, .fault_o, .fault_code_o, .irq_o);
`default_nettype wire

/* tb/csmsf_partner.sv */
// Purpose: network nodes and running program around the block
// Assumes: called right after a rising edge
// Notes:   pulses last one cycle, levels hold
`timescale 1ns/10ps
`default_nettype none
module csmsf_partner (
    input  wire logic       clk_i,
    output logic      [3:0] pulse_o,  // end, start, stored, delivered
    output logic      [1:0] level_o   // transmitting, waiting
);
    initial pulse_o = 4'h0;
    initial level_o = 2'h0;
    // one-cycle event, dropped at the next edge
    task automatic pulse(input logic [3:0] m);
        pulse_o <= m;
        @(posedge clk_i);
        pulse_o <= 4'h0;
    endtask : pulse
    // message queue state as the nodes see it
    task automatic level(input logic [1:0] v);
        level_o <= v;
    endtask : level
endmodule : csmsf_partner
`default_nettype wire

/* tb/csmsf_top_tb_top.sv */
// Purpose: self-checking bench for the status math scan block
// Assumes: short tick period, clock enable high but for one freeze test
// Notes:   one task per scenario
`timescale 1ns/10ps
`default_nettype none
module csmsf_top_tb_top;
    localparam int P = 12;            // short tick keeps the run brief
    localparam logic [7:0] A_S2 = csmsf_pkg::ADR_STATUS2;
    localparam logic [7:0] A_SC = csmsf_pkg::ADR_SCAN;
    localparam logic [7:0] A_FL = csmsf_pkg::ADR_FLAGS;
    localparam logic [7:0] A_IS = csmsf_pkg::ADR_IRQ_STAT;
    localparam logic [7:0] A_IM = csmsf_pkg::ADR_IRQ_MASK;
    // sel, op, a, b, destination, overflow
    localparam logic [51:0] MV [8] = '{
        {1'h0, 2'h0, 16'h7FFF, 16'h0001, 16'h7FFF, 1'h1},
        {1'h0, 2'h1, 16'h8000, 16'h0001, 16'h8000, 1'h1},
        {1'h1, 2'h0, 16'h7FFF, 16'h0001, 16'h8000, 1'h1},
        {1'h1, 2'h1, 16'h8000, 16'h0001, 16'h7FFF, 1'h1},
        {1'h0, 2'h2, 16'h0100, 16'h0100, 16'h7FFF, 1'h1},
        {1'h1, 2'h2, 16'h0100, 16'h0100, 16'h0000, 1'h1},
        {1'h0, 2'h3, 16'h8000, 16'hFFFF, 16'h7FFF, 1'h1},
        {1'h0, 2'h0, 16'h0001, 16'h0002, 16'h0003, 1'h0}};
    localparam logic [1:0] LV [4] = '{2'h1, 2'h3, 2'h1, 2'h0};
    logic        clk_i = 1'h0;
    logic        rst_i = 1'h1;
    logic        ce_i  = 1'h1;
    logic        cyc_i = 1'h0;
    logic        stb_i = 1'h0;
    logic        we_i  = 1'h0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [3:0]  be    = 4'hF;        // byte enables of the next cycle
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic [3:0]  pls;                 // partner pulses
    logic [1:0]  lvl;                 // partner levels
    logic        fault_o;
    logic [15:0] fault_code_o;
    logic        irq_o;
    logic [31:0] q;                   // last read word
    int          n_mismatch = 0;
    int          n_checks   = 0;
    always #20 clk_i = ~clk_i;
    csmsf_top #(.TICK_PERIOD(P)) u_csmsf_top (
        .clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
        .sel_i, .dat_i, .dat_o, .ack_o, .reply_rx_i(pls[0]),
        .reply_done_i(pls[1]), .msg_waiting_i(lvl[0]),
        .msg_xmit_i(lvl[1]), .scan_start_i(pls[2]), .prog_end_i(pls[3]),
        .fault_o, .fault_code_o, .irq_o);
    csmsf_partner u_csmsf_partner (.clk_i, .pulse_o(pls), .level_o(lvl));
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    // classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
        int n;
        n = 0;
        {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'h3, w, a, be, d};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'h1 && n < 20);
        if (ack_o !== 1'h1) begin
            n_mismatch++;
            conclude();
        end
        q = dat_o;
        {cyc_i, stb_i} <= 2'h0;
        @(posedge clk_i);
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] e, input string nm);
        wb(1'h0, a, 32'h0);
        chk(nm, e, q & m);
    endtask : rd
    task automatic t_reset;
        rd(A_S2, 32'h4000, 32'h0, "ovf sel");
        be = 4'h1;                    // limit byte lane off: write ignored
        wb(1'h1, A_SC, 32'h0500);
        be = 4'hF;
        rd(A_SC, 32'hFF00, 32'h0A00, "limit");
        wb(1'h1, A_SC, 32'h0);
        rd(A_SC, 32'hFF00, 32'h0100, "limit min");
        wb(1'h1, A_SC, 32'hFF00);
        rd(8'h40, 32'hFFFFFFFF, 32'h0, "unmapped");
    endtask : t_reset
    task automatic t_math;
        logic [51:0] v;
        foreach (MV[i]) begin
            v = MV[i];
            wb(1'h1, A_S2, {17'h0, v[51], 14'h0});
            wb(1'h1, csmsf_pkg::ADR_MATH_OP, {v[32:17], v[48:33]});
            wb(1'h1, csmsf_pkg::ADR_MATH_CMD, {30'h0, v[50:49]});
            rd(csmsf_pkg::ADR_MATH_CMD, 32'hFFFF, {16'h0, v[16:1]}, "dest");
            if (v[50:49] == csmsf_pkg::OP_MUL) chk("math reg", 32'h1, q >> 16);
            rd(A_FL, 32'h3, {30'h0, {2{v[0]}}}, "ovf flags");
            wb(1'h1, A_FL, 32'h0);
        end
    endtask : t_math
    task automatic t_trap;
        u_csmsf_partner.pulse(4'h4);
        wb(1'h1, csmsf_pkg::ADR_MATH_OP, 32'h0001_7FFF);
        wb(1'h1, csmsf_pkg::ADR_MATH_CMD, 32'h0);
        u_csmsf_partner.pulse(4'h8);
        repeat (2) @(posedge clk_i);
        chk("trap", {csmsf_pkg::FAULT_MINOR, 16'h1}, {fault_code_o, 15'h0, fault_o});
        wb(1'h1, A_FL, 32'h4);
        u_csmsf_partner.pulse(4'h8);
        repeat (2) @(posedge clk_i);
        chk("no trap", 32'h0, {31'h0, fault_o});
    endtask : t_trap
    task automatic t_scan;
        int n;
        u_csmsf_partner.pulse(4'h4);
        wb(1'h1, A_SC, 32'h0300);
        // read lands 15 cycles after start: 1.25 ticks, so count is 2
        repeat (P - 1) @(posedge clk_i);
        rd(A_SC, 32'hFF, 32'h2, "scan byte");
        n = 0;
        while (fault_o !== 1'h1 && n < 2 * P) begin
            @(posedge clk_i);
            n++;
        end
        chk("wdog", {csmsf_pkg::FAULT_WDOG, 16'h1}, {fault_code_o, 15'h0, fault_o});
        wb(1'h1, csmsf_pkg::ADR_CTRL, 32'h1);
        wb(1'h1, A_FL, 32'h4);
        rd(A_SC, 32'hFF, 32'h0, "scan zero");
        wb(1'h1, A_SC, 32'hFF00);
    endtask : t_scan
    task automatic t_msg;
        foreach (LV[i]) begin
            u_csmsf_partner.level(LV[i]);
            repeat (2) @(posedge clk_i);
            rd(A_S2, 32'h80, (LV[i] == 2'h1) ? 32'h80 : 32'h0, "out pend");
        end
        ce_i <= 1'h0;                 // frozen: the delivery is not seen
        u_csmsf_partner.pulse(4'h1);
        ce_i <= 1'h1;
        rd(A_S2, 32'h40, 32'h0, "reply frozen");
        u_csmsf_partner.pulse(4'h1);
        rd(A_S2, 32'h40, 32'h40, "reply set");
        u_csmsf_partner.pulse(4'h2);
        rd(A_S2, 32'h40, 32'h0, "reply clr");
    endtask : t_msg
    task automatic t_irq;
        logic a;
        wb(1'h1, A_IM, 32'h0);
        wb(1'h0, A_IS, 32'h0);
        u_csmsf_partner.pulse(4'h1);
        @(posedge clk_i);
        a = irq_o;
        wb(1'h1, A_IM, 32'hF);
        @(posedge clk_i);
        chk("irq masked", 32'h0, {31'h0, a});
        chk("irq unmasked", 32'h1, {31'h0, irq_o});
        rd(A_IS, 32'h4, 32'h4, "irq reply");
        @(posedge clk_i);
        chk("irq clear", 32'h0, {31'h0, irq_o});
    endtask : t_irq
    initial begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        @(posedge clk_i);
        t_reset();
        t_math();
        t_trap();
        t_scan();
        t_msg();
        t_irq();
        conclude();
    end
    // hang guard
    initial begin
        repeat (20000) @(posedge clk_i);
        n_mismatch++;
        conclude();
    end
endmodule : csmsf_top_tb_top
`default_nettype wire
